// ===== hw/acc_pkg.sv
// Package for the analog comparator control block.
// Assumes a 32-bit APB bus with byte addresses and an 8-bit register file.
package acc_pkg;

   // ========================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL_A = 8'h00; // Comparator A control
   localparam logic [7:0] OFS_CTRL_B = 8'h04; // Comparator B control
   localparam logic [7:0] OFS_SHARED = 8'h08; // Shared comparator config
   localparam logic [7:0] OFS_STATUS = 8'h0c; // Sticky interrupt status
   localparam logic [7:0] OFS_MASK = 8'h10; // Interrupt mask
   localparam logic [7:0] OFS_PORT = 8'h14; // Port pin read
   localparam logic [7:0] OFS_ANSEL = 8'h18; // Analog pin select
   localparam logic [7:0] OFS_PINDIR = 8'h1c; // Pin direction

   // ========================================
   // Control register field positions
   localparam int CTL_EN = 7; // Enable
   localparam int CTL_RES = 6; // Result, read only
   localparam int CTL_DRV = 5; // Pin drive
   localparam int CTL_INV = 4; // Result invert
   localparam int CTL_SPD = 3; // Speed select
   localparam int CTL_ROUTE = 2; // Reference route
   localparam int CTL_NEG = 0; // Negative input select, two bits

   // ========================================
   // Shared register field bases; comparator i uses base minus i
   localparam int SH_MIRROR = 7; // Mirror results
   localparam int SH_RSEL = 5; // Reference source select
   localparam int SH_HYS = 3; // Hysteresis enable
   localparam int SH_SYNC = 1; // Timer sync enable

   // ========================================
   // Reset values and write masks
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] SHARED_RST = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'hbf; // Result bit is read only
   localparam logic [7:0] SHARED_WMASK = 8'h3f; // Mirror bits read only
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [7:0] ANSEL_RST = 8'hff; // Pins start analog
   localparam logic [7:0] PINDIR_RST = 8'hff; // Pins start as inputs
   localparam int NUM_CMP = 2; // Comparators in the block

   // ========================================
   // Control register layout
   typedef struct packed {
      logic enable; // Comparator on
      logic result; // Read-only result slot
      logic pin_drive; // Result onto pin
      logic result_invert; // Output polarity
      logic speed_select; // Normal or low power
      logic ref_route; // Positive input from internal reference
      logic [1:0] neg_input_select; // Negative input channel
   } acc_ctrl_t;

   // Analog front-end steering for one comparator
   typedef struct packed {
      logic power_on; // Bias and comparator on
      logic speed_select; // Normal or low power
      logic hysteresis_enable; // Hysteresis on
      logic ref_route; // Positive input: 1 reference, 0 pin
      logic use_fixed_ref; // Selected reference: 1 fixed, 0 variable
      logic [1:0] neg_input_select; // Negative input channel
   } acc_analog_t;

endpackage

// ===== hw/acc_cmp_unit.sv
// One comparator's digital result path and interrupt mismatch latch.
// Assumes raw_in is already synchronous to pclk and tick is one cycle wide.
`timescale 1ns/10ps
module acc_cmp_unit
   import acc_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic enable, // Comparator on
   input wire logic invert, // Result polarity
   input wire logic sync_en, // Latch on timer tick
   input wire logic raw_in, // Raw comparator decision
   input wire logic tick, // Timer source clock rising edge
   input wire logic snap, // Control register read done
   output logic result, // Result seen by software
   output logic mismatch // Result differs from latch
);

   // ========================================
   // Result forming
   logic polar; // Raw result after polarity
   logic live; // Result before optional sync
   logic sync_q; // Result held on timer tick
   logic latch_q; // Mismatch reference copy

   assign polar = raw_in ^ invert;
   // Off comparator shows polarity so latches can be preset
   assign live = enable ? polar : invert;
   // Async mode passes straight through, sync mode uses the held copy
   assign result = sync_en ? sync_q : live;

   // Timer-tick latch; tick already follows any prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= 1'b0;
      end else if (tick) begin
         sync_q <= live;
      end
   end

   // ========================================
   // Mismatch latch, refreshed only by the own control read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 1'b0;
      end else if (snap) begin
         latch_q <= result;
      end
   end

   assign mismatch = result ^ latch_q;

endmodule // acc_cmp_unit

// ===== hw/acc_cmp_ctrl.sv
// Control and status register bank for two analog comparators.
// Assumes an APB master on pclk, raw comparator outputs synchronous
// to pclk and a one-cycle timer tick after the timer prescaler.
//
// How it works
// - Control bit 7 turns comparator on/off.
// - Pin driven only if drive, enable, output direction.
// - Analog pins read zero in port register.
// - Shared register mirrors both results together.
// - Source select picks fixed or variable reference.
// - Route bit picks reference or pin input.
// - Shared register holds per-comparator hysteresis enables.
// - Disabled comparator result equals its polarity bit in async mode; with sync on, from the next tick.
// - Reset clears all control registers, references off.
// - Sync bit latches result on timer tick.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
module acc_cmp_ctrl
   import acc_pkg::*;
#(
   parameter int PIN_W = 8, // Port width
   parameter int CMP_A_PIN = 2, // Port bit of comparator A output
   parameter int CMP_B_PIN = 3 // Port bit of comparator B output
) (
   input wire logic pclk, // APB clock, 25 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic pready, // APB ready
   output logic [31:0] prdata, // APB read data
   output logic pslverr, // APB error on unmapped address
   input wire logic [NUM_CMP-1:0] cmp_raw, // Raw comparator decisions
   input wire logic tmr_tick, // Timer source clock rising edge
   input wire logic [PIN_W-1:0] port_in, // Port pin levels
   output acc_analog_t [NUM_CMP-1:0] analog_cfg, // Front-end steering
   output logic vref_power_on, // Reference generators on
   output logic [NUM_CMP-1:0] cmp_pin_out, // Result onto pin
   output logic [NUM_CMP-1:0] cmp_pin_oe_n, // Pin driven when low
   output logic [PIN_W-1:0] pin_dir, // Pin direction, 1 input
   output logic irq // Level interrupt
);

   // ========================================
   // APB decode
   logic setup; // First cycle of a transfer
   logic access; // Completing cycle of a transfer
   logic wr_done; // Write takes effect
   logic rd_done; // Read completes
   logic lane0; // Low byte strobe
   logic hit_ctrl_a; // Comparator A control
   logic hit_ctrl_b; // Comparator B control
   logic hit_shared; // Shared config
   logic hit_status; // Interrupt status
   logic hit_mask; // Interrupt mask
   logic hit_port; // Port read
   logic hit_ansel; // Analog select
   logic hit_pindir; // Pin direction
   logic mapped; // Any register hit
   logic [7:0] wbyte; // Written byte

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_done = access & pwrite & lane0;
   assign rd_done = access & ~pwrite;
   assign lane0 = pstrb[0];
   assign wbyte = pwdata[7:0];

   assign hit_ctrl_a = (paddr == OFS_CTRL_A);
   assign hit_ctrl_b = (paddr == OFS_CTRL_B);
   assign hit_shared = (paddr == OFS_SHARED);
   assign hit_status = (paddr == OFS_STATUS);
   assign hit_mask = (paddr == OFS_MASK);
   assign hit_port = (paddr == OFS_PORT);
   assign hit_ansel = (paddr == OFS_ANSEL);
   assign hit_pindir = (paddr == OFS_PINDIR);
   assign mapped = hit_ctrl_a | hit_ctrl_b | hit_shared | hit_status |
                   hit_mask | hit_port | hit_ansel | hit_pindir;

   // Zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   // Unmapped addresses answer with an error, writes are dropped
   assign pslverr = access & ~mapped;

   // ========================================
   // Storage
   logic [7:0] ctrl_q [NUM_CMP]; // Control registers, result slot unused
   logic [7:0] ctrl_d [NUM_CMP]; // Next control values
   logic [7:0] shared_q; // Shared config, mirror slots unused
   logic [7:0] shared_d; // Next shared config
   logic [NUM_CMP-1:0] sts_q; // Sticky mismatch status
   logic [NUM_CMP-1:0] sts_d; // Next status
   logic [NUM_CMP-1:0] mask_q; // Interrupt mask
   logic [NUM_CMP-1:0] mask_d; // Next mask
   logic [PIN_W-1:0] ansel_q; // Analog pin select
   logic [PIN_W-1:0] ansel_d; // Next analog select
   logic [PIN_W-1:0] pindir_q; // Pin direction
   logic [PIN_W-1:0] pindir_d; // Next direction
   logic [31:0] prdata_q; // Registered read data
   logic [31:0] prdata_d; // Read mux

   // Per-comparator wires
   logic [NUM_CMP-1:0] hit_ctrl; // Control register hit
   logic [NUM_CMP-1:0] result; // Comparator results
   logic [NUM_CMP-1:0] mismatch; // Mismatch events
   logic [NUM_CMP-1:0] snap; // Own control read completes
   logic [NUM_CMP-1:0] mirror; // Mirror slot values
   acc_ctrl_t [NUM_CMP-1:0] ctrl_v; // Control fields with result
   logic [NUM_CMP-1:0] sts_clr; // Write-one-to-clear bits

   assign hit_ctrl = {hit_ctrl_b, hit_ctrl_a};

   // ========================================
   // Per-comparator logic
   genvar i;
   generate
      for (i = 0; i < NUM_CMP; i++) begin : g_cmp
         localparam int PIN = (i == 0) ? CMP_A_PIN : CMP_B_PIN;
         logic drive_ok; // All pin drive conditions met

         // Control view: stored fields plus live result bit
         assign ctrl_v[i] = acc_ctrl_t'({ctrl_q[i][7:CTL_RES+1], result[i],
                                         ctrl_q[i][CTL_RES-1:0]});

         // Control write; result slot stays zero in storage
         assign ctrl_d[i] = (wr_done & hit_ctrl[i]) ?
                            (wbyte & CTRL_WMASK) : ctrl_q[i];

         // Only a read of this control register refreshes the latch
         assign snap[i] = rd_done & hit_ctrl[i];

         acc_cmp_unit u_unit (
            .pclk(pclk),
            .presetn(presetn),
            .enable(ctrl_q[i][CTL_EN]),
            .invert(ctrl_q[i][CTL_INV]),
            .sync_en(shared_q[SH_SYNC-i]),
            .raw_in(cmp_raw[i]),
            .tick(tmr_tick),
            .snap(snap[i]),
            .result(result[i]),
            .mismatch(mismatch[i])
         );

         // Both results come from the same cycle, so no skew
         assign mirror[i] = result[i];

         // Front-end steering
         assign analog_cfg[i].power_on = ctrl_q[i][CTL_EN];
         assign analog_cfg[i].speed_select = ctrl_q[i][CTL_SPD];
         assign analog_cfg[i].hysteresis_enable = shared_q[SH_HYS-i];
         assign analog_cfg[i].ref_route = ctrl_q[i][CTL_ROUTE];
         assign analog_cfg[i].use_fixed_ref = shared_q[SH_RSEL-i];
         assign analog_cfg[i].neg_input_select =
            ctrl_q[i][CTL_NEG+1:CTL_NEG];

         // Pin carries the result only with all three conditions
         assign drive_ok = ctrl_q[i][CTL_DRV] & ctrl_q[i][CTL_EN] &
                           ~pindir_q[PIN];
         assign cmp_pin_out[i] = result[i];
         assign cmp_pin_oe_n[i] = ~drive_ok;
      end
   endgenerate

   // References only run while some comparator is on
   assign vref_power_on = |(analog_cfg[0].power_on | analog_cfg[1].power_on);

   // ========================================
   // Shared config, status, mask and port registers
   assign shared_d = (wr_done & hit_shared) ?
                     (wbyte & SHARED_WMASK) : shared_q;

   // A set in the same cycle as its clear wins
   assign sts_clr = (wr_done & hit_status) ? wbyte[NUM_CMP-1:0] : '0;
   assign sts_d = (sts_q & ~sts_clr) | mismatch;

   assign mask_d = (wr_done & hit_mask) ? wbyte[NUM_CMP-1:0] : mask_q;
   assign ansel_d = (wr_done & hit_ansel) ? wbyte[PIN_W-1:0] : ansel_q;
   assign pindir_d = (wr_done & hit_pindir) ? wbyte[PIN_W-1:0] : pindir_q;

   // ========================================
   // Read mux
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (hit_ctrl_a) begin
         prdata_d[7:0] = ctrl_v[0];
      end else if (hit_ctrl_b) begin
         prdata_d[7:0] = ctrl_v[1];
      end else if (hit_shared) begin
         // Mirror reads do not touch the mismatch latches
         prdata_d[7:0] = shared_q;
         prdata_d[SH_MIRROR] = mirror[0];
         prdata_d[SH_MIRROR-1] = mirror[1];
      end else if (hit_status) begin
         prdata_d[NUM_CMP-1:0] = sts_q;
      end else if (hit_mask) begin
         prdata_d[NUM_CMP-1:0] = mask_q;
      end else if (hit_port) begin
         // Analog pins read zero whatever the pin level
         prdata_d[PIN_W-1:0] = port_in & ~ansel_q;
      end else if (hit_ansel) begin
         prdata_d[PIN_W-1:0] = ansel_q;
      end else if (hit_pindir) begin
         prdata_d[PIN_W-1:0] = pindir_q;
      end else begin
         prdata_d = 32'h0000_0000; // Unmapped reads as zero
      end
   end

   // Capture read data in setup so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;

   // ========================================
   // Control registers; reset turns both comparators off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q[0] <= CTRL_RST;
         ctrl_q[1] <= CTRL_RST;
         shared_q <= SHARED_RST;
      end else begin
         ctrl_q[0] <= ctrl_d[0];
         ctrl_q[1] <= ctrl_d[1];
         shared_q <= shared_d;
      end
   end

   // Interrupt status and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= IRQ_RST;
         mask_q <= IRQ_RST;
      end else begin
         sts_q <= sts_d;
         mask_q <= mask_d;
      end
   end

   // Port configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ansel_q <= ANSEL_RST;
         pindir_q <= PINDIR_RST;
      end else begin
         ansel_q <= ansel_d;
         pindir_q <= pindir_d;
      end
   end

   assign pin_dir = pindir_q;

   // Level interrupt while any unmasked status bit is set
   assign irq = |(sts_q & mask_q);

endmodule // acc_cmp_ctrl

// ===== dv/acc_cmp_monitor.sv
// Port assertions for the comparator control block.
// Assumes one clock domain; bound to every acc_cmp_ctrl instance.
`timescale 1ns/10ps
module acc_cmp_monitor
   import acc_pkg::*;
#(
   parameter int PIN_W = 8, // Port width
   parameter int CMP_A_PIN = 2, // Pin of A
   parameter int CMP_B_PIN = 3 // Pin of B
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Access phase
   input wire logic pwrite, // Direction
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [3:0] pstrb, // Strobes
   input wire logic [31:0] prdata, // Read data
   input wire logic [PIN_W-1:0] port_in, // Pin levels
   input wire acc_analog_t [NUM_CMP-1:0] analog_cfg, // Steering
   input wire logic vref_power_on, // Reference power
   input wire logic [NUM_CMP-1:0] cmp_pin_out, // Results
   input wire logic [NUM_CMP-1:0] cmp_pin_oe_n, // Drive, low
   input wire logic [PIN_W-1:0] pin_dir // Direction, 1 input
);
   // ========================================
   // Decoded bus events
   wire wr_ok = psel & penable & pwrite & pstrb[0]; // Write lands
   wire wr_a = wr_ok & (paddr == OFS_CTRL_A); // Control A write
   wire wr_b = wr_ok & (paddr == OFS_CTRL_B); // Control B write
   wire wr_sh = wr_ok & (paddr == OFS_SHARED); // Shared write
   wire rd_set = psel & ~penable & ~pwrite; // Read data captured here
   logic [7:0] ansel_m; // Analog select as last written
   logic sync_b_m; // Sync bit of B as last written
   // Shadow of bus-written config that the ports do not show
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ansel_m <= ANSEL_RST;
         sync_b_m <= SHARED_RST[SH_SYNC-1];
      end else begin
         if (wr_ok && paddr == OFS_ANSEL) begin
            ansel_m <= pwdata[7:0];
         end
         if (wr_sh) begin
            sync_b_m <= pwdata[SH_SYNC-1];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========================================
   // Properties
   property p_enable;
      wr_b |=> analog_cfg[1].power_on == $past(pwdata[CTL_EN]);
   endproperty
   a_enable: assert property (p_enable) else $error("B enable not taken");
   property p_pin_drive;
      !cmp_pin_oe_n[1] |-> analog_cfg[1].power_on && !pin_dir[CMP_B_PIN];
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("B pin driven");
   // Analog-selected pins read zero, digital pins follow the pin
   property p_port_zero;
      rd_set && paddr == OFS_PORT |=>
         prdata[7:0] == ($past(port_in[7:0]) & ~$past(ansel_m));
   endproperty
   a_port_zero: assert property (p_port_zero) else $error("Port bit set");
   property p_mirror;
      rd_set && paddr == OFS_SHARED |=>
         prdata[7:6] == {$past(cmp_pin_out[0]), $past(cmp_pin_out[1])};
   endproperty
   a_mirror: assert property (p_mirror) else $error("Mirror bits wrong");
   property p_ref_select;
      wr_sh |=> analog_cfg[0].use_fixed_ref == $past(pwdata[SH_RSEL])
         && analog_cfg[1].use_fixed_ref == $past(pwdata[SH_RSEL-1]);
   endproperty
   a_ref_select: assert property (p_ref_select) else $error("Ref select");
   property p_ref_route;
      wr_a |=> analog_cfg[0].ref_route == $past(pwdata[CTL_ROUTE]);
   endproperty
   a_ref_route: assert property (p_ref_route) else $error("Ref route");
   property p_hysteresis;
      wr_sh |=> analog_cfg[0].hysteresis_enable == $past(pwdata[SH_HYS])
         && analog_cfg[1].hysteresis_enable == $past(pwdata[SH_HYS-1]);
   endproperty
   a_hysteresis: assert property (p_hysteresis) else $error("Hysteresis");
   // Async case only; with sync on the held copy waits for a tick
   property p_disabled;
      wr_b && !pwdata[CTL_EN] && !sync_b_m |=> cmp_pin_out[1] == $past(pwdata[CTL_INV]);
   endproperty
   a_disabled: assert property (p_disabled) else $error("Off result");
   property p_reset;
      $rose(presetn) |-> analog_cfg == '0 && !vref_power_on && cmp_pin_oe_n == 2'h3;
   endproperty
   a_reset: assert property (p_reset) else $error("Not reset");
endmodule // acc_cmp_monitor

bind acc_cmp_ctrl acc_cmp_monitor #(.PIN_W(PIN_W), .CMP_A_PIN(CMP_A_PIN),
   .CMP_B_PIN(CMP_B_PIN)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .port_in(port_in), .analog_cfg(analog_cfg),
   .vref_power_on(vref_power_on), .cmp_pin_out(cmp_pin_out),
   .cmp_pin_oe_n(cmp_pin_oe_n), .pin_dir(pin_dir));

// ===== dv/acc_cmp_ctrl_tb.sv
// Self-checking bench for the comparator control block.
// Assumes the monitor file is compiled alongside; one 25 MHz clock.
`timescale 1ns/10ps
module acc_cmp_ctrl_tb
   import acc_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tmr_tick = 0;
   logic [7:0] paddr = 0, port_in = 8'ha5;
   logic [31:0] pwdata = 0, prdata, r;
   logic [3:0] pstrb = 0;
   logic [1:0] cmp_raw = 0, cmp_pin_out, cmp_pin_oe_n;
   logic pready, pslverr, vref_power_on, irq, e;
   logic [7:0] pin_dir;
   acc_analog_t [NUM_CMP-1:0] analog_cfg;
   int n_errors = 0, checks = 0, cyc = 0;
   acc_cmp_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cmp_raw(cmp_raw), .tmr_tick(tmr_tick),
      .port_in(port_in), .analog_cfg(analog_cfg), .vref_power_on(vref_power_on),
      .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_n(cmp_pin_oe_n), .pin_dir(pin_dir),
      .irq(irq));
   always #20 pclk = ~pclk;
   // ========================================
   // Hang guard, far above the few hundred cycles needed
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks++;
      if (got !== ex) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // ========================================
   // APB cycle: setup, access held until pready at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, 24'h0, d, s};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Write, then let the register update settle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1, a, d, 4'h1, r, e);
      @(negedge pclk);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(0, a, 0, 4'h0, r, e);
      chk(nm, ex, r);
   endtask
   // Inputs move only on the rising edge
   task automatic raw(input logic [1:0] v);
      @(posedge pclk);
      cmp_raw <= v;
      @(negedge pclk);
   endtask
   // ========================================
   // Scenarios
   task automatic t_reset();
      for (int i = 0; i < 8; i++) rchk("reset", 8'(i * 4), (i > 5) ? 8'hff : 8'h00);
      chk("oe_n", 2'h3, cmp_pin_oe_n);
      $display("test reset done");
   endtask
   task automatic t_enable();
      raw(2'b10);
      wr(OFS_CTRL_B, 8'h8f);
      chk("cfg_b", 7'h6b, analog_cfg[1]);
      chk("vref", 1, vref_power_on);
      rchk("ctrl_b", OFS_CTRL_B, 8'hcf);
      wr(OFS_CTRL_B, 8'h00);
      chk("on_b", 0, analog_cfg[1].power_on);
      wr(OFS_CTRL_A, 8'h04);
      chk("route_a", 1, analog_cfg[0].ref_route);
      wr(OFS_CTRL_A, 8'h00);
      $display("test enable done");
   endtask
   task automatic t_pin();
      for (int i = 0; i < 8; i++) begin
         wr(OFS_PINDIR, i[0] ? 8'hff : 8'hf7);
         wr(OFS_CTRL_B, {i[2], 1'b0, i[1], 5'h00});
         chk("oe_n_b", !(i[2] && i[1] && !i[0]), cmp_pin_oe_n[1]);
      end
      wr(OFS_PINDIR, 8'hfb);
      chk("pin_dir", 8'hfb, pin_dir);
      wr(OFS_CTRL_A, 8'ha0);
      chk("oe_n_a", 0, cmp_pin_oe_n[0]);
      wr(OFS_CTRL_A, 8'h00);
      chk("oe_n_a", 1, cmp_pin_oe_n[0]);
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_PINDIR, 8'hff);
      $display("test pin done");
   endtask
   task automatic t_port();
      wr(OFS_ANSEL, 8'h0f);
      rchk("port", OFS_PORT, 8'ha0);
      wr(OFS_ANSEL, 8'h00);
      rchk("port", OFS_PORT, 8'ha5);
      $display("test port done");
   endtask
   // Stale latch keeps re-setting status until its own control read
   task automatic t_mirror();
      raw(2'b00);
      wr(OFS_CTRL_A, 8'h80);
      wr(OFS_CTRL_B, 8'h90);
      rchk("ctrl_a", OFS_CTRL_A, 8'h80);
      rchk("ctrl_b", OFS_CTRL_B, 8'hd0);
      wr(OFS_STATUS, 8'h03);
      wr(OFS_MASK, 8'h03);
      rchk("status", OFS_STATUS, 8'h00);
      raw(2'b01);
      rchk("shared", OFS_SHARED, 8'hc0);
      wr(OFS_STATUS, 8'h03);
      rchk("status", OFS_STATUS, 8'h01);
      chk("irq", 1, irq);
      wr(OFS_MASK, 8'h02);
      chk("irq", 0, irq);
      rchk("ctrl_a", OFS_CTRL_A, 8'hc0);
      wr(OFS_STATUS, 8'h03);
      rchk("status", OFS_STATUS, 8'h00);
      wr(OFS_CTRL_B, 8'h10);
      chk("off_b", 1, cmp_pin_out[1]);
      rchk("ctrl_b", OFS_CTRL_B, 8'h50);
      wr(OFS_CTRL_B, 8'h00);
      chk("off_b", 0, cmp_pin_out[1]);
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_MASK, 8'h00);
      $display("test mirror done");
   endtask
   task automatic t_shared();
      logic [7:0] v [2] = '{8'h28, 8'h14};
      foreach (v[k]) begin
         wr(OFS_SHARED, v[k]);
         chk("fix", {v[k][4], v[k][5]}, {analog_cfg[1].use_fixed_ref,
            analog_cfg[0].use_fixed_ref});
         chk("hys", {v[k][2], v[k][3]}, {analog_cfg[1].hysteresis_enable,
            analog_cfg[0].hysteresis_enable});
      end
      wr(OFS_SHARED, 8'hff);
      rchk("shared", OFS_SHARED, 8'h3f);
      wr(OFS_SHARED, 8'h02);
      wr(OFS_CTRL_A, 8'h80);
      raw(2'b01);
      chk("sync", 0, cmp_pin_out[0]);
      @(posedge pclk);
      tmr_tick <= 1;
      @(posedge pclk);
      tmr_tick <= 0;
      raw(2'b00);
      chk("sync", 1, cmp_pin_out[0]);
      wr(OFS_SHARED, 8'h00);
      chk("async", 0, cmp_pin_out[0]);
      wr(OFS_CTRL_A, 8'h00);
      $display("test shared done");
   endtask
   task automatic t_bad();
      apb(0, 8'h20, 8'h00, 4'h0, r, e);
      chk("slverr", 1, e);
      chk("bad_rd", 0, r);
      chk("pready", 1, pready);
      apb(1, OFS_MASK, 8'h03, 4'h0, r, e);
      rchk("mask", OFS_MASK, 8'h00);
      $display("test bad done");
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_enable();
      t_pin();
      t_port();
      t_mirror();
      t_shared();
      t_bad();
      give_verdict();
   end
endmodule // acc_cmp_ctrl_tb
